// *** hdl/sfdp_pkg.sv ***
// Constants and types for the discovery parameter table block
package sfdp_pkg;
	// Link command framing
	localparam logic [7:0] READ_OP    = 8'h5A; // Discovery read code
	localparam logic [4:0] CMD_LAST   = 5'h07; // Eight command bits
	localparam logic [4:0] ADDR_LAST  = 5'h17; // Always three address bytes
	localparam logic [4:0] DUMMY_LAST = 5'h07; // Eight dummy clocks
	localparam int         TAB_AW     = 11;    // 2048-byte table space

	// Data buffer shape
	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 16;

	// Byte locations inside the table
	localparam logic [10:0] A_OPT     = 11'h032;
	localparam logic [10:0] A_DENS    = 11'h034;
	localparam logic [10:0] A_DENS_HI = 11'h037;
	localparam logic [10:0] A_QIO_T   = 11'h038;
	localparam logic [10:0] A_QIO_OP  = 11'h039;
	localparam logic [10:0] A_QO_T    = 11'h03A;
	localparam logic [10:0] A_QO_OP   = 11'h03B;
	localparam logic [10:0] A_DO_T    = 11'h03C;
	localparam logic [10:0] A_DO_OP   = 11'h03D;
	localparam logic [10:0] A_DIO_T   = 11'h03E;
	localparam logic [10:0] A_DIO_OP  = 11'h03F;
	localparam logic [10:0] A_PROTO   = 11'h040;
	localparam logic [10:0] A_P2_T    = 11'h046;
	localparam logic [10:0] A_P2_OP   = 11'h047;
	localparam logic [10:0] A_P4_T    = 11'h04A;
	localparam logic [10:0] A_P4_OP   = 11'h04B;
	localparam logic [10:0] A_ER1_SZ  = 11'h04C;
	localparam logic [10:0] A_ER1_OP  = 11'h04D;
	localparam logic [10:0] A_ER2_SZ  = 11'h04E;
	localparam logic [10:0] A_ER2_OP  = 11'h04F;
	localparam logic [10:0] A_ER34_LO = 11'h050;
	localparam logic [10:0] A_ER34_HI = 11'h053;

	// Field values
	localparam logic [0:0] FR_DO     = 1'h1; // Dual output fast read
	localparam logic [1:0] ADDR_MODE = 2'h1; // 3 or 4 byte selectable
	localparam logic [0:0] DTR_OK    = 1'h1;
	localparam logic [0:0] FR_DIO    = 1'h1;
	localparam logic [0:0] FR_QIO    = 1'h1;
	localparam logic [0:0] FR_QO     = 1'h1;
	localparam logic [0:0] RSV_BIT   = 1'h1;
	localparam logic [2:0] RSV_3     = 3'h7;
	localparam logic [4:0] DUMMY_Q   = 5'h09; // Quad address reads
	localparam logic [4:0] DUMMY_S   = 5'h07; // Other fast reads
	localparam logic [2:0] XIP_BITS  = 3'h1;
	localparam logic [31:0] DENSITY  = 32'h1FFFFFFF; // Bits minus one
	localparam logic [7:0] OP_QIO    = 8'hEB;
	localparam logic [7:0] OP_QO     = 8'h6B;
	localparam logic [7:0] OP_DO     = 8'h3B;
	localparam logic [7:0] OP_DIO    = 8'hBB;
	localparam logic [7:0] SZ_4K     = 8'h0C;
	localparam logic [7:0] OP_ER4K   = 8'h20;
	localparam logic [7:0] SZ_64K    = 8'h10;
	localparam logic [7:0] OP_ER64K  = 8'hD8;
	localparam logic [7:0] ABSENT    = 8'h00;
	localparam logic [7:0] RSV_BYTE  = 8'hFF;

	// Link sequencer states
	typedef enum logic [2:0] {
		ST_CMD    = 3'b000,
		ST_ADDR   = 3'b001,
		ST_DUMMY  = 3'b010,
		ST_DATA   = 3'b011,
		ST_IGNORE = 3'b100
	} link_state_type;
endpackage

// *** hdl/sfdp_parameter_table_rom.sv ***
// Discovery parameter table served over the serial link, with its buffer
// How it works
// [RULE1] Byte 32h bit0 reports dual output read
// [RULE2] Byte 32h bits 2:1 read 01b
// [RULE3] Byte 32h bit3 reports double rate clocking
// [RULE4] Byte 32h bits 6:4 and 7 read one
// [RULE5] Byte 38h holds nine dummies, one XIP
// [RULE6] Byte 39h holds EBh
// [RULE7] Byte 3Ah holds seven dummies, one XIP
// [RULE8] Byte 3Bh holds 6Bh
// [RULE9] Byte 3Ch holds seven dummies, one XIP
// [RULE10] Byte 3Dh holds 3Bh
// [RULE11] Byte 3Eh holds seven dummies, one XIP
// [RULE12] Byte 3Fh holds BBh
// [RULE13] Byte 40h reads all ones
// [RULE14] Byte 46h holds seven dummies, one XIP
// [RULE15] Byte 47h holds BBh
// [RULE16] Byte 4Ah holds nine dummies, one XIP
// [RULE17] Byte 4Bh holds EBh
// [RULE18] Erase type one: 0Ch size, 20h code
// [RULE19] Erase type two: 10h size, D8h code
// [RULE20] Bytes 50h to 53h read zero
// [RULE21] Density bytes FFh FFh FFh 1Fh, low first
// [RULE22] Reserved bytes read all ones
// [RULE23] Code, three address bytes, eight dummies, data
// [RULE24] Address increments, wraps at 2048, ends deselected
`timescale 1ns/1ps
`default_nettype none

// Plain synchronous FIFO with a flush
module sfdp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             i_core_clk,
	input  wire logic             i_reset,
	input  wire logic             i_flush,
	// Fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [PW:0]      wr_ptr_r;    // Extra bit tells full from empty
	logic [PW:0]      rd_ptr_r;
	logic             push;
	logic             pop;

	assign o_in_ready  = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {PW{1'b0}}};
	assign o_out_valid = wr_ptr_r != rd_ptr_r;
	assign o_out_data  = mem[rd_ptr_r[PW-1:0]];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// Storage write, no reset needed on data
	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem[wr_ptr_r[PW-1:0]] <= i_in_data;
		end
	end

	// Pointers; flush drops all words at once
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else if (i_flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule

// Link-facing table reader
module sfdp_parameter_table_rom (
	// Clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_reset,
	// Serial link from the host
	input  wire logic i_sclk,
	input  wire logic i_cs_n,
	input  wire logic i_dq0,
	// Serial data back to the host
	output logic      o_dq1,
	output logic      o_dq1_oe
);
	// Table lookup; anything not listed is reserved and reads ones
	function automatic logic [7:0] table_byte(input logic [10:0] a);
		logic [1:0] di;
		di = 2'(a - sfdp_pkg::A_DENS);
		table_byte = sfdp_pkg::RSV_BYTE; // [RULE22]
		if (a >= sfdp_pkg::A_DENS && a <= sfdp_pkg::A_DENS_HI) begin
			table_byte = sfdp_pkg::DENSITY[8*di +: 8]; // [RULE21]
		end else if (a >= sfdp_pkg::A_ER34_LO
			&& a <= sfdp_pkg::A_ER34_HI) begin
			table_byte = sfdp_pkg::ABSENT; // [RULE20]
		end else begin
			case (a)
				sfdp_pkg::A_OPT: table_byte = {sfdp_pkg::RSV_BIT,
					sfdp_pkg::FR_QO, sfdp_pkg::FR_QIO, // [RULE4]
					sfdp_pkg::FR_DIO, sfdp_pkg::DTR_OK, // [RULE3]
					sfdp_pkg::ADDR_MODE, // [RULE2]
					sfdp_pkg::FR_DO}; // [RULE1]
				sfdp_pkg::A_QIO_T: table_byte =
					{sfdp_pkg::XIP_BITS, sfdp_pkg::DUMMY_Q}; // [RULE5]
				sfdp_pkg::A_QIO_OP: table_byte = sfdp_pkg::OP_QIO; // [RULE6]
				sfdp_pkg::A_QO_T: table_byte =
					{sfdp_pkg::XIP_BITS, sfdp_pkg::DUMMY_S}; // [RULE7]
				sfdp_pkg::A_QO_OP: table_byte = sfdp_pkg::OP_QO; // [RULE8]
				sfdp_pkg::A_DO_T: table_byte =
					{sfdp_pkg::XIP_BITS, sfdp_pkg::DUMMY_S}; // [RULE9]
				sfdp_pkg::A_DO_OP: table_byte = sfdp_pkg::OP_DO; // [RULE10]
				sfdp_pkg::A_DIO_T: table_byte =
					{sfdp_pkg::XIP_BITS, sfdp_pkg::DUMMY_S}; // [RULE11]
				sfdp_pkg::A_DIO_OP: table_byte = sfdp_pkg::OP_DIO; // [RULE12]
				sfdp_pkg::A_PROTO: table_byte = {sfdp_pkg::RSV_3,
					sfdp_pkg::FR_QIO, sfdp_pkg::RSV_3,
					sfdp_pkg::FR_DIO}; // [RULE13]
				sfdp_pkg::A_P2_T: table_byte =
					{sfdp_pkg::XIP_BITS, sfdp_pkg::DUMMY_S}; // [RULE14]
				sfdp_pkg::A_P2_OP: table_byte = sfdp_pkg::OP_DIO; // [RULE15]
				sfdp_pkg::A_P4_T: table_byte =
					{sfdp_pkg::XIP_BITS, sfdp_pkg::DUMMY_Q}; // [RULE16]
				sfdp_pkg::A_P4_OP: table_byte = sfdp_pkg::OP_QIO; // [RULE17]
				sfdp_pkg::A_ER1_SZ: table_byte = sfdp_pkg::SZ_4K; // [RULE18]
				sfdp_pkg::A_ER1_OP: table_byte = sfdp_pkg::OP_ER4K; // [RULE18]
				sfdp_pkg::A_ER2_SZ: table_byte = sfdp_pkg::SZ_64K; // [RULE19]
				sfdp_pkg::A_ER2_OP: table_byte = sfdp_pkg::OP_ER64K; // [RULE19]
				default: table_byte = sfdp_pkg::RSV_BYTE; // [RULE22]
			endcase
		end
	endfunction

	// Synchronised pins: bit 2 clock, bit 1 select, bit 0 data
	logic [2:0] pin_raw;
	logic [2:0] pin_s;
	logic       sclk_d_r;  // Previous synced link clock
	logic       rise;      // Host samples, device captures
	logic       fall;      // Device launches next bit
	logic       cs_act;    // Frame is open

	// Sequencer
	sfdp_pkg::link_state_type state_r;
	logic [4:0]  cnt_r;        // Bits seen in current phase
	logic [23:0] shift_r;      // Command and address shifter
	logic        addr_done_r;  // One pulse when address is complete
	logic [10:0] start_addr_r; // Table start within 2048 bytes

	// Fill side of the buffer
	logic        fill_act_r;
	logic [10:0] fill_addr_r;
	logic [7:0]  push_data;
	logic        push_ready;
	logic        push_fire;

	// Drain side and serialiser
	logic        pop_valid;
	logic [7:0]  pop_data;
	logic        pop_ready;
	logic [7:0]  out_byte_r;
	logic [7:0]  ser_next;
	logic [2:0]  bit_cnt_r;
	logic        dq1_r;
	logic        oe_r;

	assign pin_raw = {i_sclk, i_cs_n, i_dq0};

	// Two flops per pin; only the second flop is read by logic
	for (genvar g = 0; g < 3; g++) begin : g_sync
		logic s1_r;
		logic s2_r;
		always_ff @(posedge i_core_clk or posedge i_reset) begin
			if (i_reset) begin
				s1_r <= (g == 1) ? 1'b1 : 1'b0; // Idle: select high, rest low
				s2_r <= (g == 1) ? 1'b1 : 1'b0;
			end else begin
				s1_r <= pin_raw[g];
				s2_r <= s1_r;
			end
		end
		assign pin_s[g] = s2_r;
	end

	// Link clock edge finder; the link clock is far slower than ours
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= pin_s[2];
		end
	end

	assign rise   = pin_s[2] & ~sclk_d_r;
	assign fall   = ~pin_s[2] & sclk_d_r;
	assign cs_act = ~pin_s[1];

	// Command, address and dummy phases on rising link edges
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			state_r      <= sfdp_pkg::ST_CMD;
			cnt_r        <= 5'h00;
			shift_r      <= 24'h000000;
			addr_done_r  <= 1'b0;
			start_addr_r <= 11'h000;
		end else if (!cs_act) begin
			// Deselect ends any read at once
			state_r     <= sfdp_pkg::ST_CMD; // [RULE24]
			cnt_r       <= 5'h00;
			addr_done_r <= 1'b0;
		end else begin
			addr_done_r <= 1'b0;
			if (rise) begin
				shift_r <= {shift_r[22:0], pin_s[0]};
				case (state_r)
					sfdp_pkg::ST_CMD: begin
						if (cnt_r == sfdp_pkg::CMD_LAST) begin
							cnt_r <= 5'h00;
							// Unknown codes are left to other logic
							if ({shift_r[6:0], pin_s[0]} == sfdp_pkg::READ_OP) begin
								state_r <= sfdp_pkg::ST_ADDR; // [RULE23]
							end else begin
								state_r <= sfdp_pkg::ST_IGNORE;
							end
						end else begin
							cnt_r <= cnt_r + 5'h01;
						end
					end
					sfdp_pkg::ST_ADDR: begin
						// Three bytes even in 4-byte mode
						if (cnt_r == sfdp_pkg::ADDR_LAST) begin
							cnt_r        <= 5'h00;
							state_r      <= sfdp_pkg::ST_DUMMY; // [RULE23]
							addr_done_r  <= 1'b1;
							start_addr_r <= {shift_r[9:0], pin_s[0]};
						end else begin
							cnt_r <= cnt_r + 5'h01;
						end
					end
					sfdp_pkg::ST_DUMMY: begin
						if (cnt_r == sfdp_pkg::DUMMY_LAST) begin
							cnt_r   <= 5'h00;
							state_r <= sfdp_pkg::ST_DATA; // [RULE23]
						end else begin
							cnt_r <= cnt_r + 5'h01;
						end
					end
					sfdp_pkg::ST_DATA,
					sfdp_pkg::ST_IGNORE: begin
						// Held until deselect
						state_r <= state_r;
					end
					default: state_r <= sfdp_pkg::ST_IGNORE;
				endcase
			end
		end
	end

	// Prefetch: lookups start during the dummy phase so bytes wait ready
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			fill_act_r  <= 1'b0;
			fill_addr_r <= 11'h000;
		end else if (!cs_act) begin
			fill_act_r <= 1'b0;
		end else if (addr_done_r) begin
			fill_act_r  <= 1'b1;
			fill_addr_r <= start_addr_r;
		end else if (push_fire) begin
			// Eleven bits roll over from 7FFh to zero
			fill_addr_r <= fill_addr_r + 11'h001; // [RULE24]
		end
	end

	assign push_data = table_byte(fill_addr_r);
	assign push_fire = fill_act_r & push_ready;

	// Buffer between table lookup and serialiser
	sfdp_fifo #(
		.WIDTH (sfdp_pkg::DATA_W),
		.DEPTH (sfdp_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_core_clk  (i_core_clk),
		.i_reset     (i_reset),
		.i_flush     (!cs_act),
		.i_in_valid  (fill_act_r),
		.i_in_data   (push_data),
		.o_in_ready  (push_ready),
		.o_out_valid (pop_valid),
		.o_out_data  (pop_data),
		.i_out_ready (pop_ready)
	);

	// A byte is taken on the falling edge that launches its top bit
	assign pop_ready = cs_act & fall & (state_r == sfdp_pkg::ST_DATA)
		& (bit_cnt_r == 3'h0);
	// Empty buffer cannot happen at link rate; ones are sent if it does
	assign ser_next = (bit_cnt_r == 3'h0)
		? (pop_valid ? pop_data : sfdp_pkg::RSV_BYTE)
		: {out_byte_r[6:0], 1'b0};

	// Serialiser: most significant bit first on falling link edges
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			out_byte_r <= 8'h00;
			bit_cnt_r  <= 3'h0;
			dq1_r      <= 1'b0;
			oe_r       <= 1'b0;
		end else if (!cs_act) begin
			bit_cnt_r <= 3'h0;
			oe_r      <= 1'b0; // [RULE24]
		end else if (fall && state_r == sfdp_pkg::ST_DATA) begin
			out_byte_r <= ser_next;
			dq1_r      <= ser_next[7];
			bit_cnt_r  <= bit_cnt_r + 3'h1;
			oe_r       <= 1'b1;
		end
	end

	assign o_dq1    = dq1_r;
	assign o_dq1_oe = oe_r;

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	sequence s_addr_end;
		rise && cs_act && state_r == sfdp_pkg::ST_ADDR
			&& cnt_r == sfdp_pkg::ADDR_LAST;
	endsequence
	sequence s_fill_start;
		addr_done_r ##1 fill_act_r;
	endsequence

	opt_byte_a: assert property (push_fire && fill_addr_r == // [RULE1]
		sfdp_pkg::A_OPT |-> push_data == 8'hFB)
		else $error("option byte wrong");
	addr_mode_a: assert property (push_fire && fill_addr_r == // [RULE2]
		sfdp_pkg::A_OPT |-> push_data[2:1] == 2'h1)
		else $error("address mode field wrong");
	qio_time_a: assert property (push_fire && fill_addr_r == // [RULE5]
		sfdp_pkg::A_QIO_T |-> push_data == 8'h29)
		else $error("quad address timing wrong");
	qo_op_a: assert property (push_fire && fill_addr_r == // [RULE8]
		sfdp_pkg::A_QO_OP |-> push_data == 8'h6B)
		else $error("quad output code wrong");
	do_time_a: assert property (push_fire && fill_addr_r == // [RULE9]
		sfdp_pkg::A_DO_T |-> push_data == 8'h27)
		else $error("dual output timing wrong");
	proto_byte_a: assert property (push_fire && fill_addr_r == // [RULE13]
		sfdp_pkg::A_PROTO |-> push_data == 8'hFF)
		else $error("protocol byte wrong");
	p4_op_a: assert property (push_fire && fill_addr_r == // [RULE17]
		sfdp_pkg::A_P4_OP |-> push_data == 8'hEB)
		else $error("quad protocol code wrong");
	erase_one_a: assert property (push_fire && fill_addr_r == // [RULE18]
		sfdp_pkg::A_ER1_OP |-> push_data == 8'h20)
		else $error("small erase code wrong");
	erase_two_a: assert property (push_fire && fill_addr_r == // [RULE19]
		sfdp_pkg::A_ER2_SZ |-> push_data == 8'h10)
		else $error("large erase size wrong");
	absent_types_a: assert property (push_fire && fill_addr_r[10:2] == // [RULE20]
		9'h014 |-> push_data == 8'h00)
		else $error("absent erase type not zero");
	density_top_a: assert property (push_fire && fill_addr_r == // [RULE21]
		sfdp_pkg::A_DENS_HI |-> push_data == 8'h1F)
		else $error("density top byte wrong");
	reserved_a: assert property (push_fire && (fill_addr_r == 11'h033 // [RULE22]
		|| fill_addr_r == 11'h048) |-> push_data == 8'hFF)
		else $error("reserved byte not ones");
	addr_start_a: assert property (s_addr_end |=> s_fill_start) // [RULE23]
		else $error("prefetch did not start after address");
	table_wrap_a: assert property (push_fire && cs_act // [RULE24]
		&& fill_addr_r == 11'h7FF |=> fill_addr_r == 11'h000)
		else $error("table address did not wrap");
	deselect_a: assert property (!cs_act |=> !o_dq1_oe) // [RULE24]
		else $error("output still driven after deselect");
	first_bit_a: assert property (pop_ready && pop_valid // [RULE23]
		|=> o_dq1 == $past(pop_data[7]) && o_dq1_oe)
		else $error("first data bit not launched");
endmodule

`default_nettype wire

// *** sim/spi_host_model.sv ***
// Host side model that issues discovery reads over the serial link
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	// Core clock, paces the link and clocks the enable watch
	input  wire logic i_core_clk,
	// Link towards the device
	output var logic  o_sclk,
	output var logic  o_cs_n,
	output var logic  o_dq0,
	input  wire logic i_dq1,
	input  wire logic i_dq1_oe
);
	logic [7:0] rx [0:63]; // Whole bytes received in the last frame
	int         rx_n;      // Number of whole bytes received
	int         oe_low;    // Data samples taken with the enable low
	logic       oe_seen = 1'b0; // Enable seen high while selected
	logic       cs_q = 1'b1;    // Select one core cycle ago

	// Link idle at time zero, serial clock parked low
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_dq0 = 1'b0;
		rx_n = 0;
		oe_low = 0;
	end

	// Watch the enable through the whole frame, not only at samples
	always @(posedge i_core_clk) begin
		cs_q <= o_cs_n;
		if (cs_q && !o_cs_n) begin
			oe_seen <= 1'b0; // New frame, forget the last one
		end else if (!o_cs_n && i_dq1_oe === 1'b1) begin
			oe_seen <= 1'b1;
		end
	end

	// Half a link period: 10 core cycles gives the 80 ns link clock
	task automatic half();
		repeat (10) @(negedge i_core_clk);
	endtask

	// One frame: code, address, dummies, then nbits of data clocks
	task automatic frame(input logic [7:0] op, input logic [23:0] addr,
		input int nbits);
		logic [39:0] hdr; // Code, three address bytes, dummy pattern
		logic [7:0]  sh;  // Shift register for incoming data
		hdr = {op, addr, 8'h55};
		sh = 8'h00;
		rx_n = 0;
		oe_low = 0;
		@(negedge i_core_clk);
		o_cs_n = 1'b0;
		// Always three address bytes and eight dummy clocks
		for (int i = 39; i >= 0; i--) begin
			o_dq0 = hdr[i];
			half();
			o_sclk = 1'b1;
			half();
			o_sclk = 1'b0;
		end
		// Sample just before each rise, long after the device shifted
		for (int b = 0; b < nbits; b++) begin
			o_dq0 = ~o_dq0; // Unused input never keeps a stale value
			half();
			sh = {sh[6:0], i_dq1};
			if (i_dq1_oe !== 1'b1) begin
				oe_low++;
			end
			if (b % 8 == 7) begin
				rx[rx_n] = sh;
				rx_n++;
			end
			o_sclk = 1'b1;
			half();
			o_sclk = 1'b0;
		end
		half();
		// Deselect ends the read, a partial byte is simply dropped
		o_cs_n = 1'b1;
		o_dq0 = ~o_dq0;
	endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the discovery table reader and its buffer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic       i_core_clk; // 250 MHz core clock
	logic       i_reset;    // Async reset, active high
	logic       sclk;       // Link clock from the host model
	logic       cs_n;       // Select, active low
	logic       dq0;        // Host to device data
	logic       dq1;        // Device to host data
	logic       dq1_oe;     // Device drives its data line
	int         error_cnt = 0;
	int         num_checks = 0;

	// Table reader facing the host model
	sfdp_parameter_table_rom i_dut (
		.i_core_clk(i_core_clk), .i_reset(i_reset), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_dq0(dq0), .o_dq1(dq1), .o_dq1_oe(dq1_oe));

	// Far side of the link
	spi_host_model i_host (
		.i_core_clk(i_core_clk), .o_sclk(sclk), .o_cs_n(cs_n),
		.o_dq0(dq0), .i_dq1(dq1), .i_dq1_oe(dq1_oe));

	// Clock generator
	initial i_core_clk = 1'b0;
	always #2 i_core_clk = ~i_core_clk;

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Expected table contents, bytes outside 32h..53h read all ones
	function automatic logic [7:0] exp_byte(input logic [10:0] a);
		case (a)
			11'h032: return 8'hFB;
			11'h037: return 8'h1F;
			11'h038, 11'h04A: return 8'h29;
			11'h039, 11'h04B: return 8'hEB;
			11'h03A, 11'h03C: return 8'h27;
			11'h03E, 11'h046: return 8'h27;
			11'h03B: return 8'h6B;
			11'h03D: return 8'h3B;
			11'h03F, 11'h047: return 8'hBB;
			11'h040: return 8'hFF;
			11'h04C: return 8'h0C;
			11'h04D: return 8'h20;
			11'h04E: return 8'h10;
			11'h04F: return 8'hD8;
			11'h050, 11'h051, 11'h052, 11'h053: return 8'h00;
			default: return 8'hFF;
		endcase
	endfunction

	// Deselected gap, enable must be gone before the next frame
	task automatic gap();
		repeat (6) @(negedge i_core_clk);
		chk(dq1_oe, 1'b0);
	endtask

	// Whole table in one burst, upper address bits set and ignored
	task automatic t_table();
		i_host.frame(sfdp_pkg::READ_OP, 24'hFFF832, 34 * 8);
		chk(i_host.rx_n, 34);
		chk(i_host.oe_low, 0);
		for (int i = 0; i < 34; i++) begin
			chk(i_host.rx[i], exp_byte(11'(11'h032 + i)));
		end
		gap();
	endtask

	// Unknown code: the rest of the frame is ignored
	task automatic t_bad_op();
		i_host.frame(8'h03, 24'h000032, 16);
		chk(i_host.oe_seen, 1'b0);
		gap();
	endtask

	// Abort in mid-byte, then a fresh frame right behind it
	task automatic t_abort();
		i_host.frame(sfdp_pkg::READ_OP, 24'h000038, 11);
		chk(i_host.rx_n, 1);
		chk(i_host.rx[0], 8'h29);
		gap();
		i_host.frame(sfdp_pkg::READ_OP, 24'h00003B, 8);
		chk(i_host.rx[0], 8'h6B);
		gap();
	endtask

	// Burst across the 2048-byte boundary back to the table start
	task automatic t_wrap();
		i_host.frame(sfdp_pkg::READ_OP, 24'h0007FF, 52 * 8);
		chk(i_host.rx_n, 52);
		for (int i = 0; i < 52; i++) begin
			chk(i_host.rx[i], exp_byte(11'(11'h7FF + i)));
		end
		chk(i_host.rx[51], 8'hFB);
		gap();
	endtask

	// Buffer seen through the top: it stays full ahead of the link,
	// refuses the lookup side, and deselect empties it
	task automatic t_fifo();
		i_host.frame(sfdp_pkg::READ_OP, 24'h000040, 20 * 8);
		chk(i_dut.push_ready, 1'b0);
		chk(i_dut.pop_valid, 1'b1);
		chk(i_host.rx_n, 20);
		chk(i_host.oe_low, 0);
		for (int i = 0; i < 20; i++) begin
			chk(i_host.rx[i], exp_byte(11'(11'h040 + i)));
		end
		gap();
		chk(i_dut.pop_valid, 1'b0);
	endtask

	// Counts, verdict and end of run
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence, inputs change on falling edges
	initial begin
		i_reset = 1'b1;
		repeat (3) @(posedge i_core_clk);
		@(negedge i_core_clk);
		i_reset = 1'b0;
		repeat (3) @(negedge i_core_clk);
		t_table();
		t_bad_op();
		t_abort();
		t_wrap();
		t_fifo();
		report_and_stop();
	end

	// Watchdog: the tests need about 23000 cycles
	initial begin
		repeat (60000) @(posedge i_core_clk);
		error_cnt++;
		report_and_stop();
	end
endmodule
`default_nettype wire
